/* File: verilog/adcr_core.sv */
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module adcr_core import adcr_pkg::*; #(
    parameter int RAW_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADCR_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog core side
    input wire logic cmp_i,
    input wire logic alt_clk_i,
    input wire logic stop_i,
    output logic [RAW_W-1:0] dac_code_o,
    output logic sample_o,
    output logic busy_o,
    output logic [4:0] channel_o,
    output logic low_power_o,
    output logic async_clk_run_o,
    // Interrupt
    output logic irq_o
);
    typedef struct packed {
        adcr_state_t fsm;
        logic [4:0] ch;
        logic cont;
        logic conversion_complete_flag;
        logic [9:0] res;
        logic lock;
        logic [7:0] ck;
        logic [1:0] ists;
        logic [1:0] ien;
        logic irq;
        logic ack;
        logic [7:0] dat;
        logic [RAW_W-1:0] sar;
        logic [3:0] bitn;
        logic [7:0] scnt;
        logic alt_q;
        logic arun;
        logic smp;
        logic bsy;
    } adcr_st_t;

    adcr_st_t st_r;
    adcr_st_t st_nxt;
    logic req;
    logic wr;
    logic rd;
    logic mode10;
    logic in_tick;
    logic converter_clock;
    logic atick;
    logic stop_kill;
    logic done;
    logic [2:0] div_m1;
    logic [3:0] async_m1;

    // Bit counter and rounding shifts need 11 to 16 raw bits
    if (RAW_W < 11 || RAW_W > 16) begin : g_raw_chk
        $error("adcr_core: RAW_W must be 11..16");
    end

    // Sample length in input-clock ticks, half cycles rounded up
    function automatic logic [7:0] samp_m1(input logic lsmp,
                                          input logic [1:0] dv);
        int h;
        h = (lsmp ? LONG_HALVES : SHORT_HALVES) * (1 << dv);
        samp_m1 = 8'((h + 1) / 2 - 1); // (R11)
    endfunction

    // Round the raw code to 8 or 10 bits with saturation
    function automatic logic [9:0] rnd(input logic [RAW_W-1:0] r,
                                       input logic m10);
        logic [RAW_W:0] s;
        logic [RAW_W:0] lim;
        int sh;
        sh = m10 ? RAW_W - 10 : RAW_W - 8;
        s = {1'b0, r} + ((RAW_W+1)'(1) << (sh - 1)); // (R10)
        s = s >> sh;
        lim = m10 ? (RAW_W+1)'(1023) : (RAW_W+1)'(255);
        rnd = (s > lim) ? lim[9:0] : s[9:0];
    endfunction

    // Bus request decode; the answer comes one cycle later
    assign req = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign mode10 = st_r.ck[CK_MODE +: 2] == MODE_10; // (R8)
    assign stop_kill = stop_i && !st_r.ck[CK_ACLK]; // (R13)
    assign done = st_r.fsm == ST_FINISH;

    // Input clock choice: async, bus or alternate edge
    always_comb begin
        if (st_r.ck[CK_ACLK]) begin
            in_tick = atick; // (R12)
        end else if (st_r.ck[CK_ICS]) begin
            in_tick = 1'b1; // (R7)
        end else begin
            in_tick = alt_clk_i && !st_r.alt_q; // (R7)
        end
    end

    // Divide codes map to /1 /2 /4 /8
    assign div_m1 = 3'((4'h1 << st_r.ck[CK_DIV +: 2]) - 4'h1); // (R6)
    // Low power halves the async clock rate
    assign async_m1 = st_r.ck[CK_LPC] ? 4'(ASYNC_SLOW_CYC - 1)
                                      : 4'(ASYNC_FAST_CYC - 1); // (R14)

    // Converter clock; held in restart through sampling
    adcr_tick_div #(.CW(3)) u_converter_clock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(st_r.fsm != ST_CONVERT),
        .en_i(in_tick),
        .period_m1_i(div_m1),
        .tick_o(converter_clock)
    );

    // Async clock generator, only alive while the sequencer is not idle
    adcr_tick_div #(.CW(4)) u_async (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(!st_r.arun),
        .en_i(1'b1),
        .period_m1_i(async_m1),
        .tick_o(atick)
    );

    // Next state: bus reads, sequencer, bus writes, stop, then flag sets
    always_comb begin
        st_nxt = st_r;
        st_nxt.alt_q = alt_clk_i;
        st_nxt.ack = req;
        st_nxt.dat = 8'h00;
        // Read data and read side effects
        if (rd) begin
            unique case (wb_adr_i)
                OFS_SC: st_nxt.dat = {st_r.conversion_complete_flag, 1'b0, st_r.cont, st_r.ch};
                OFS_RH: begin
                    // 8-bit mode keeps high byte zero
                    st_nxt.dat = mode10 ? {6'h00, st_r.res[9:8]} // (R19)
                                        : 8'h00; // (R1)
                    if (mode10) begin
                        st_nxt.lock = 1'b1; // (R2)
                    end
                end
                OFS_RL: begin
                    st_nxt.dat = st_r.res[7:0];
                    st_nxt.lock = 1'b0; // (R2)
                    st_nxt.conversion_complete_flag = 1'b0; // (R16)
                end
                OFS_CLK: st_nxt.dat = st_r.ck;
                OFS_IST: st_nxt.dat = {6'h00, st_r.ists};
                OFS_IEN: st_nxt.dat = {6'h00, st_r.ien};
                default: st_nxt.dat = 8'h00;
            endcase
        end
        // Sequencer progress
        unique case (st_r.fsm)
            ST_IDLE: begin
            end
            ST_SAMPLE: begin
                if (in_tick) begin
                    if (st_r.scnt == 8'h00) begin
                        st_nxt.fsm = ST_CONVERT;
                        st_nxt.bitn = 4'(RAW_W - 1);
                        st_nxt.sar = {1'b1, {(RAW_W-1){1'b0}}};
                    end else begin
                        st_nxt.scnt = st_r.scnt - 8'h01; // (R11)
                    end
                end
            end
            ST_CONVERT: begin
                if (converter_clock) begin
                    // Keep the trial bit only if input is above it
                    if (!cmp_i) begin
                        st_nxt.sar[st_r.bitn] = 1'b0;
                    end
                    if (st_r.bitn == 4'h0) begin
                        st_nxt.fsm = ST_FINISH;
                    end else begin
                        st_nxt.bitn = st_r.bitn - 4'h1;
                        st_nxt.sar[st_r.bitn - 4'h1] = 1'b1;
                    end
                end
            end
            ST_FINISH: begin
                if (!(st_r.lock && mode10)) begin
                    st_nxt.res = rnd(st_r.sar, mode10); // (R5)
                end
                if (st_r.cont) begin
                    st_nxt.fsm = ST_SAMPLE;
                    st_nxt.scnt = samp_m1(st_r.ck[CK_LSMP],
                                          st_r.ck[CK_DIV +: 2]);
                end else begin
                    st_nxt.fsm = ST_IDLE;
                end
            end
        endcase
        // Register writes
        if (wr) begin
            unique case (wb_adr_i)
                OFS_SC: begin
                    st_nxt.ch = wb_dat_i[4:0];
                    st_nxt.cont = wb_dat_i[SC_CONT];
                    st_nxt.conversion_complete_flag = 1'b0; // (R16)
                    // All-ones channel parks the converter
                    if (wb_dat_i[4:0] != CH_OFF) begin
                        st_nxt.fsm = ST_SAMPLE; // (R17)
                        st_nxt.scnt = samp_m1(st_r.ck[CK_LSMP],
                                              st_r.ck[CK_DIV +: 2]);
                    end else begin
                        st_nxt.fsm = ST_IDLE; // (R17)
                    end
                end
                OFS_CLK: begin
                    // New clocking invalidates any run in flight
                    st_nxt.ck = wb_dat_i[7:0];
                    st_nxt.cont = 1'b0; // (R18)
                    st_nxt.fsm = ST_IDLE; // (R18)
                    st_nxt.lock = 1'b0; // (R4)
                end
                OFS_ICLR: st_nxt.ists = st_r.ists & ~wb_dat_i[1:0];
                OFS_IEN: st_nxt.ien = wb_dat_i[1:0];
                default: begin
                end
            endcase
        end
        // Stop mode without the async clock halts the sequencer and ends continuous mode
        if (stop_kill) begin
            st_nxt.fsm = ST_IDLE; // (R13)
            st_nxt.cont = 1'b0; // (R18)
        end
        // A completion beats a same-cycle clear
        if (done) begin
            st_nxt.conversion_complete_flag = 1'b1;
            st_nxt.ists[IRQ_DONE] = 1'b1;
            if (st_r.lock && mode10) begin
                st_nxt.ists[IRQ_LOST] = 1'b1; // (R3)
            end
        end
        st_nxt.irq = |(st_nxt.ists & st_nxt.ien);
        st_nxt.arun = st_nxt.ck[CK_ACLK] && st_nxt.fsm != ST_IDLE; // (R12)
        st_nxt.smp = st_nxt.fsm == ST_SAMPLE;
        st_nxt.bsy = st_nxt.fsm != ST_IDLE;
    end

    // State register; reset parks in 8-bit mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.fsm <= ST_IDLE;
            st_r.ch <= CH_RST;
            st_r.ck <= CK_RST; // (R9)
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = {24'h000000, st_r.dat};
    assign irq_o = st_r.irq;
    assign dac_code_o = st_r.sar;
    assign sample_o = st_r.smp;
    assign busy_o = st_r.bsy;
    assign channel_o = st_r.ch;
    assign low_power_o = st_r.ck[CK_LPC];
    assign async_clk_run_o = st_r.arun;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // High byte never shows bits above the result
    hi_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_RH
        |-> wb_dat_o[7:2] == 6'h00 && (mode10 || wb_dat_o[1:0] == 2'h0))
        else $error("result high unused bits nonzero"); // (R1)

    // Locked results stay put until the low read
    lock_hold_a: assert property (st_r.lock && !(rd && wb_adr_i == OFS_RL)
        |=> $stable(st_r.res))
        else $error("result changed while locked"); // (R2)

    // A completion under lock is recorded as lost
    lost_flag_a: assert property (done && st_r.lock && mode10
        |=> st_r.ists[IRQ_LOST] && $stable(st_r.res))
        else $error("locked completion not discarded"); // (R3)

    // No interlock outside 10-bit mode
    no_lock8_a: assert property (!mode10 |-> !st_r.lock)
        else $error("interlock active in 8-bit mode"); // (R4)

    // Divide by 4 leaves three idle input ticks between edges
    sequence div4_edge_s;
        converter_clock && st_r.ck[CK_ICS] && !st_r.ck[CK_ACLK]
            && st_r.ck[CK_DIV +: 2] == 2'h2 && !done && !req && !stop_kill;
    endsequence
    div4_gap_a: assert property (div4_edge_s ##1 st_r.fsm == ST_CONVERT
        |-> !converter_clock[*3])
        else $error("converter clock period wrong"); // (R6)

    // Alternate source ticks only on its rising edge
    alt_sel_a: assert property (!st_r.ck[CK_ACLK] && !st_r.ck[CK_ICS]
        && !(alt_clk_i && !st_r.alt_q) |-> !in_tick)
        else $error("alternate clock select broken"); // (R7)

    // Reset leaves 8-bit mode
    rst_mode_a: assert property ($past(rst_i)
        |-> st_r.ck[CK_MODE +: 2] == MODE_8)
        else $error("reset did not select 8-bit"); // (R9)

    // Stored result is the rounded raw code
    round_a: assert property (done && !(st_r.lock && mode10)
        |=> st_r.res == rnd($past(st_r.sar), $past(mode10)))
        else $error("result not rounded"); // (R10)

    // Short sample at bus clock /1 lasts four cycles
    sequence short_start_s;
        wr && wb_adr_i == OFS_SC && wb_dat_i[4:0] != CH_OFF
            && !st_r.ck[CK_LSMP] && st_r.ck[CK_ICS]
            && !st_r.ck[CK_ACLK] && st_r.ck[CK_DIV +: 2] == 2'h0
            && !stop_i;
    endsequence
    sequence short_quiet_s;
        (!stop_kill && !req)[*4];
    endsequence
    sample_len_a: assert property (short_start_s ##1 short_quiet_s
        |-> ##1 (!st_r.smp && $past(st_r.smp) && $past(st_r.smp, 4)))
        else $error("short sample length wrong"); // (R11)

    // Async generator runs, and ticks, only while busy
    async_run_a: assert property (async_clk_run_o
        == (st_r.ck[CK_ACLK] && busy_o) && (async_clk_run_o || !atick))
        else $error("async clock runs while idle"); // (R12)

    // Stop without async clock ends conversion next cycle
    stop_halt_a: assert property (stop_kill |=> !busy_o && !st_r.cont)
        else $error("stop did not halt converter"); // (R13)

    // Status write clears complete unless a result lands
    conversion_complete_flag_clr_a: assert property (wr && wb_adr_i == OFS_SC && !done
        |=> !st_r.conversion_complete_flag)
        else $error("complete flag not cleared"); // (R16)

    // Status write with a live channel starts sampling
    start_a: assert property (wr && wb_adr_i == OFS_SC
        && wb_dat_i[4:0] != CH_OFF && !stop_kill |=> sample_o)
        else $error("status write did not start"); // (R17)

    // Clock register write ends continuous runs
    clk_stop_a: assert property (wr && wb_adr_i == OFS_CLK
        |=> !st_r.cont && !busy_o)
        else $error("clock write left converter running"); // (R18)
endmodule

/* File: verilog/adcr_pkg.sv */
// Functional notes
// (R1) Result high holds MSBs, unused bits zero
// (R2) Reading result high locks until low read
// (R3) Completions during lock are discarded
// (R4) No interlock in 8-bit mode
// (R5) Result low takes LSBs each completion
// (R6) Divider codes 00..11 give /1 /2 /4 /8
// (R7) Select bit: 1 bus clock, 0 alternate
// (R8) Mode 00 8-bit, 01 10-bit, rest reserved
// (R9) Reset selects 8-bit mode
// (R10) Results rounded to half an LSB
// (R11) Sample phase 23.5 or 3.5 cycles
// (R12) Async clock: runs only while converting
// (R13) Without async clock, stop halts conversions
// (R14) Low power slows async clock
// (R15) Software prefers bus clock when alternate slow
// (R16) Status write or low read clears complete
// (R17) Status write restarts unless channel all ones
// (R18) Continuous stops on reset, stop, writes
// (R19) 10-bit MSBs low in high reg; 8-bit zero
package adcr_pkg;
    // Register byte offsets
    localparam int ADCR_AW = 5;
    localparam logic [4:0] OFS_SC = 5'h00;
    localparam logic [4:0] OFS_RH = 5'h04;
    localparam logic [4:0] OFS_RL = 5'h08;
    localparam logic [4:0] OFS_CLK = 5'h0C;
    localparam logic [4:0] OFS_IST = 5'h10;
    localparam logic [4:0] OFS_ICLR = 5'h14;
    localparam logic [4:0] OFS_IEN = 5'h18;
    // Status/control fields
    localparam int SC_CONVERSION_COMPLETE_FLAG = 7;
    localparam int SC_CONT = 5;
    localparam logic [4:0] CH_OFF = 5'h1F;
    localparam logic [4:0] CH_RST = 5'h1F;
    // Clock config fields
    localparam int CK_LPC = 7;
    localparam int CK_DIV = 5;
    localparam int CK_LSMP = 4;
    localparam int CK_MODE = 2;
    localparam int CK_ICS = 1;
    localparam int CK_ACLK = 0;
    localparam logic [7:0] CK_RST = 8'h00;
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_10 = 2'h1;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_LOST = 1;
    // Sample phase in half converter cycles
    localparam int SHORT_HALVES = 7;
    localparam int LONG_HALVES = 47;
    // Async clock rates in kHz (upper ends of ranges)
    localparam int CLK_KHZ = 10000;
    localparam int ASYNC_FAST_KHZ = 2000;
    localparam int ASYNC_SLOW_KHZ = 1000;
    localparam int ASYNC_FAST_CYC = CLK_KHZ / ASYNC_FAST_KHZ;
    localparam int ASYNC_SLOW_CYC = CLK_KHZ / ASYNC_SLOW_KHZ;
    // Converter sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_FINISH
    } adcr_state_t;
endpackage

/* File: verilog/adcr_tick_div.sv */
`timescale 1ns/100ps
// Pulse once every (period_m1_i + 1) enabled input ticks
module adcr_tick_div #(
    parameter int CW = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic [CW-1:0] period_m1_i,
    // Output pulse
    output logic tick_o
);
    logic [CW-1:0] cnt_r;

    // Refuse a counter with no bits at elaboration
    if (CW < 1) begin : g_cw_chk
        $error("adcr_tick_div: CW must be positive");
    end

    // Terminal count on an enabled input tick
    assign tick_o = en_i && !clr_i && (cnt_r >= period_m1_i);

    // Restart keeps the phase aligned to a conversion start
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_r <= '0;
        end else if (tick_o) begin
            cnt_r <= '0;
        end else if (en_i) begin
            cnt_r <= cnt_r + CW'(1);
        end
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import adcr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADCR_AW-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cmp_i;
    logic alt_clk_i = 1'b0;
    logic stop_i = 1'b0;
    logic [11:0] dac_code_o;
    logic sample_o, busy_o, low_power_o, async_clk_run_o, irq_o;
    logic [4:0] channel_o;
    logic [11:0] tgt = 12'h000;
    logic [1:0] alt_cnt = 2'h0;
    int fails = 0;
    int tests_run = 0;
    logic [7:0] q;
    int a, b;
    logic ar;

    // 10 MHz clock; alternate source runs at a quarter of it
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        alt_cnt <= alt_cnt + 2'h1;
        alt_clk_i <= alt_cnt[1];
    end
    // Ideal comparator: continuous, as the analog core would be
    assign cmp_i = (tgt >= dac_code_o);

    adcr_core u_adcr_core (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_i(cmp_i),
        .alt_clk_i(alt_clk_i), .stop_i(stop_i), .dac_code_o(dac_code_o),
        .sample_o(sample_o), .busy_o(busy_o), .channel_o(channel_o),
        .low_power_o(low_power_o), .async_clk_run_o(async_clk_run_o),
        .irq_o(irq_o));

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [4:0] ad,
                       input logic [7:0] d, output logic [7:0] rq);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= ad;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rq = wb_dat_o[7:0];
        if (n >= 50) chk("bus ack", 0, 1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] ad, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, ad, d, x);
    endtask

    task automatic rd(input logic [4:0] ad);
        bus(1'b0, ad, 8'h00, q);
    endtask

    // Bounded wait for the converter to go idle
    task automatic idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) chk("idle", 0, 1);
    endtask

    task automatic conv(input logic [11:0] t);
        tgt <= t;
        wr(OFS_SC, 8'h00);
        idle();
    endtask

    // Sample-phase length in clocks; offsets cancel in a difference
    task automatic meas(input logic [7:0] cfg, output int n);
        int k;
        n = 0;
        k = 0;
        wr(OFS_CLK, cfg);
        wr(OFS_SC, 8'h00);
        while (busy_o !== 1'b0 && k < 3000) begin
            @(posedge clk_i);
            k++;
            if (sample_o === 1'b1) n++;
            if (async_clk_run_o === 1'b1) ar = 1'b1;
        end
        if (k >= 3000) chk("meas", 0, 1);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_regs();
        rd(OFS_CLK);
        chk("clock reset", q, 8'h00);
        chk("channel reset", channel_o, 5'h1F);
        rd(5'h1C);
        chk("unmapped", q, 8'h00);
        wr(OFS_CLK, 8'hB5);
        rd(OFS_CLK);
        chk("clock rw", q, 8'hB5);
        chk("low power", low_power_o, 1'b1);
        $display("t_regs done");
    endtask

    task automatic t_res8();
        wr(OFS_CLK, 8'h02);
        conv(12'h018);
        rd(OFS_RH);
        chk("rh 8bit", q, 8'h00);
        rd(OFS_RL);
        chk("rl round", q, 8'h02);
        conv(12'hFFF);
        rd(OFS_RL);
        chk("rl full", q, 8'hFF);
        rd(OFS_RH);
        conv(12'h0F0);
        rd(OFS_RL);
        chk("rl no lock", q, 8'h0F);
        $display("t_res8 done");
    endtask

    task automatic t_lock10();
        wr(OFS_CLK, 8'h06);
        conv(12'hAAE);
        rd(OFS_RH);
        chk("rh 10bit", q, 8'h02);
        rd(OFS_RL);
        chk("rl 10bit", q, 8'hAC);
        rd(OFS_RH);
        conv(12'hC02);
        rd(OFS_RL);
        chk("rl locked", q, 8'hAC);
        rd(OFS_IST);
        chk("lost flag", q[IRQ_LOST], 1'b1);
        conv(12'hC02);
        rd(OFS_RH);
        chk("rh unlocked", q, 8'h03);
        rd(OFS_RL);
        chk("rl unlocked", q, 8'h01);
        $display("t_lock10 done");
    endtask

    task automatic t_conversion_complete_flag_irq();
        wr(OFS_CLK, 8'h02);
        rd(OFS_RH);
        chk("rh 8bit stale", q, 8'h00);
        wr(OFS_ICLR, 8'h03);
        wr(OFS_IEN, 8'h01);
        conv(12'h100);
        rd(OFS_SC);
        chk("conversion_complete_flag set", q[SC_CONVERSION_COMPLETE_FLAG], 1'b1);
        chk("irq high", irq_o, 1'b1);
        rd(OFS_RL);
        rd(OFS_SC);
        chk("conversion_complete_flag rl clr", q[SC_CONVERSION_COMPLETE_FLAG], 1'b0);
        wr(OFS_ICLR, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", irq_o, 1'b0);
        wr(OFS_IEN, 8'h00);
        conv(12'h100);
        chk("irq masked", irq_o, 1'b0);
        rd(OFS_IST);
        chk("status sticky", q[IRQ_DONE], 1'b1);
        wr(OFS_SC, CH_OFF);
        rd(OFS_SC);
        chk("conversion_complete_flag sc clr", q[SC_CONVERSION_COMPLETE_FLAG], 1'b0);
        wr(OFS_SC, 8'h00);
        wr(OFS_SC, CH_OFF);
        repeat (3) @(posedge clk_i);
        chk("ch off idle", busy_o, 1'b0);
        chk("channel", channel_o, CH_OFF);
        wr(OFS_ICLR, 8'h03);
        $display("t_conversion_complete_flag_irq done");
    endtask

    task automatic t_div();
        for (int d = 0; d < 4; d++) begin
            meas({1'b0, d[1:0], 1'b1, 4'h2}, a);
            meas({1'b0, d[1:0], 1'b0, 4'h2}, b);
            chk("sample span", a - b, 20 * (1 << d));
        end
        $display("t_div done");
    endtask

    task automatic t_src();
        meas(8'h10, a);
        meas(8'h00, b);
        chk("alt clock", (a - b >= 76) && (a - b <= 84), 1'b1);
        ar = 1'b0;
        meas(8'h11, a);
        meas(8'h01, b);
        chk("async fast", (a - b >= 95) && (a - b <= 105), 1'b1);
        chk("async runs", ar, 1'b1);
        meas(8'h91, a);
        meas(8'h81, b);
        chk("async slow", (a - b >= 190) && (a - b <= 210), 1'b1);
        chk("gen off idle", async_clk_run_o, 1'b0);
        $display("t_src done");
    endtask

    task automatic t_stop();
        wr(OFS_CLK, 8'h02);
        wr(OFS_SC, 8'h00);
        stop_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk("stop aborts", busy_o, 1'b0);
        stop_i <= 1'b0;
        wr(OFS_CLK, 8'h01);
        tgt <= 12'h300;
        wr(OFS_SC, 8'h00);
        stop_i <= 1'b1;
        idle();
        rd(OFS_SC);
        chk("stop async", q[SC_CONVERSION_COMPLETE_FLAG], 1'b1);
        stop_i <= 1'b0;
        $display("t_stop done");
    endtask

    task automatic t_cont();
        wr(OFS_CLK, 8'h02);
        wr(OFS_SC, 8'h20);
        a = 0;
        repeat (200) begin
            @(posedge clk_i);
            if (busy_o !== 1'b1) a++;
        end
        chk("continuous", a, 0);
        wr(OFS_CLK, 8'h02);
        repeat (3) @(posedge clk_i);
        chk("clk wr stops", busy_o, 1'b0);
        wr(OFS_SC, 8'h20);
        wr(OFS_SC, 8'h00);
        idle();
        repeat (50) @(posedge clk_i);
        chk("sc wr single", busy_o, 1'b0);
        $display("t_cont done");
    endtask

    // Watchdog about ten times the expected run of some 3k cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        chk("watchdog", 0, 1);
        conclude();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_res8();
        t_lock10();
        t_conversion_complete_flag_irq();
        t_div();
        t_src();
        t_stop();
        t_cont();
        conclude();
    end
endmodule
